// File: hdl/sadec_pkg.sv
// constants for the per-slot accumulate and decimate datapath
// assumes a single 250 MHz clock and an APB register bus with 32-bit data
package sadec_pkg;
	localparam int NUM_SLOTS = 12;
	localparam int SLOT_W = 4;
	localparam int ACC_W = 32;
	localparam int ADC_W = 14;
	localparam int PULSE_W = 5;
	localparam int CIC_MAX = 4;
	localparam int DEC_W = 7;
	localparam int FIFO_BYTES = 512;
	localparam int FIFO_DEPTH = FIFO_BYTES / 4;
	localparam int FIFO_AW = 7;
	localparam int ADDR_W = 12;
	// global registers
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_FIFO_DATA = 12'h004;
	localparam logic [11:0] OFS_FIFO_LEVEL = 12'h008;
	// per-slot block: base + slot * stride
	localparam logic [11:0] OFS_SLOT_BASE = 12'h040;
	localparam logic [11:0] OFS_SLOT_END = 12'h100;
	localparam int SLOT_STRIDE_SH = 4;
	localparam logic [1:0] SREG_CFG = 2'h0;
	localparam logic [1:0] SREG_POL = 2'h1;
	localparam logic [1:0] SREG_SIGNAL = 2'h2;
	localparam logic [1:0] SREG_DARK = 2'h3;
	// slot configuration fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_HOLD_BIT = 2;
	localparam int CFG_TYPE_LSB = 4;
	localparam int CFG_DECIM_LSB = 8;
	localparam int CFG_DSHIFT_LSB = 16;
	localparam int CFG_SSHIFT_LSB = 21;
	localparam int CFG_DSIZE_LSB = 26;
	localparam int CFG_SSIZE_LSB = 29;
	localparam logic [31:0] CFG_RESET = 32'h9000_0000;
	localparam logic [31:0] POL_RESET = 32'h0000_0000;
	// status fields
	localparam int STAT_OFLOW_BIT = 12;
	localparam int STAT_UFLOW_BIT = 13;
	localparam logic [31:0] FIFO_EMPTY_WORD = 32'hFFFF_FFFF;
	typedef enum logic [1:0] {SADEC_STANDARD, SADEC_DIGINT, SADEC_IMPULSE, SADEC_SPARE} sadec_mode_t;
endpackage

// File: hdl/sadec_top.sv
// per-slot accumulate, clip, decimate and output stage with APB registers and output FIFO
// assumes sample and slot events come from logic on sys_clk, one event per cycle
// What this block does
// - each slot keeps an unsigned 32-bit positive and negative accumulator
// - accumulators saturate at all-ones instead of wrapping
// - standard mode routes each sample by the pulse's polarity select bit
// - digital integration mode routes lit samples positive, dark samples negative
// - impulse mode sums into the positive accumulator, result goes straight to FIFO
// - at slot end, signal equals positive minus negative accumulator
// - negative signal and dark results are clamped to zero
// - data registers update only when a decimated output completes; the FIFO also gets a word at each impulse-mode slot end
// - the slot's data flag is set when a decimated output completes, even while its hold bit keeps the data registers
// - one output per decimation ratio field plus one slot values
// - decimated output is the block sum or the CIC filter output, never divided
// - final values may be right-shifted before entering the FIFO
// - filter type zero is block sum, others select CIC up to fourth order
// - dark data always uses block sum at the same ratio
// - every slot keeps independent filter state
// - the whole decimation path is 32 bits wide
// - results readable from per-slot data registers and a 512-byte FIFO
// - each slot uses its own ratio and writes FIFO at its own rate
// - shift selectable 0 to 31 bits, saturating when significant bits are lost
`timescale 1ns/10ps
`default_nettype none
module sadec_top (
	input wire logic sys_clk, // 250 MHz clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [3:0] evtSlot, // slot of the current event
	input wire logic slotStart, // pulse: slot pulse operations begin
	input wire logic slotEnd, // pulse: slot pulse operations finished
	input wire logic smpValid, // pulse: adc sample present
	input wire logic [13:0] smpData, // adc sample
	input wire logic [4:0] smpPulse, // pulse index of the sample
	input wire logic smpDark, // sample taken in the dark region
	output logic [11:0] dataFlags // sticky per-slot data flags
);
	function automatic logic [31:0] satAdd(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b};
		satAdd = s[32] ? 32'hFFFF_FFFF : s[31:0];
	endfunction

	function automatic logic [31:0] shiftSat(input logic [31:0] v, input logic [4:0] sh, input logic [2:0] size);
		logic [31:0] t;
		logic [31:0] lim;
		t = v >> sh;
		case (size)
			3'h1: lim = 32'h0000_00FF;
			3'h2: lim = 32'h0000_FFFF;
			3'h3: lim = 32'h00FF_FFFF;
			default: lim = 32'hFFFF_FFFF;
		endcase
		shiftSat = (t > lim) ? lim : t;
	endfunction

	logic [31:0] cfgReg [sadec_pkg::NUM_SLOTS];
	logic [31:0] polReg [sadec_pkg::NUM_SLOTS];
	logic [31:0] posAcc [sadec_pkg::NUM_SLOTS];
	logic [31:0] negAcc [sadec_pkg::NUM_SLOTS];
	logic [31:0] darkSum [sadec_pkg::NUM_SLOTS];
	logic [31:0] sigSum [sadec_pkg::NUM_SLOTS];
	logic [31:0] integ [sadec_pkg::NUM_SLOTS][sadec_pkg::CIC_MAX];
	logic [31:0] combDly [sadec_pkg::NUM_SLOTS][sadec_pkg::CIC_MAX];
	logic [6:0] decCnt [sadec_pkg::NUM_SLOTS];
	logic [31:0] sigData_reg [sadec_pkg::NUM_SLOTS];
	logic [31:0] darkData_reg [sadec_pkg::NUM_SLOTS];
	logic [31:0] fifoMem [sadec_pkg::FIFO_DEPTH];
	logic [7:0] wrPtr_reg;
	logic [7:0] rdPtr_reg;
	logic [7:0] fifoLevel;
	logic fifoOflow_reg;
	logic fifoUflow_reg;

	// event decode
	logic slotOk, toNeg;
	logic [31:0] cfgCur, posBase, negBase, smpWide;
	sadec_pkg::sadec_mode_t modeCur;
	logic [6:0] decimCur;
	logic [2:0] orderCur, dSize, sSize;

	assign slotOk = evtSlot < 4'(sadec_pkg::NUM_SLOTS);
	assign cfgCur = slotOk ? cfgReg[evtSlot] : sadec_pkg::CFG_RESET;
	assign modeCur = sadec_pkg::sadec_mode_t'(cfgCur[sadec_pkg::CFG_MODE_LSB +: 2]);
	assign decimCur = cfgCur[sadec_pkg::CFG_DECIM_LSB +: sadec_pkg::DEC_W];
	assign orderCur = (cfgCur[sadec_pkg::CFG_TYPE_LSB +: 3] > 3'(sadec_pkg::CIC_MAX)) ?
		3'(sadec_pkg::CIC_MAX) : cfgCur[sadec_pkg::CFG_TYPE_LSB +: 3];
	assign dSize = cfgCur[sadec_pkg::CFG_DSIZE_LSB +: 3];
	assign sSize = cfgCur[sadec_pkg::CFG_SSIZE_LSB +: 3];
	assign smpWide = {18'h00000, smpData};

	always_comb
	begin
		case (modeCur)
			sadec_pkg::SADEC_STANDARD: toNeg = slotOk && polReg[evtSlot][smpPulse];
			sadec_pkg::SADEC_DIGINT: toNeg = smpDark;
			default: toNeg = 1'b0;
		endcase
	end

	// a start in the same cycle as a sample clears first, then adds
	assign posBase = (slotStart || !slotOk) ? 32'h0000_0000 : posAcc[evtSlot];
	assign negBase = (slotStart || !slotOk) ? 32'h0000_0000 : negAcc[evtSlot];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < sadec_pkg::NUM_SLOTS; i++)
			begin
				posAcc[i] <= 32'h0000_0000;
				negAcc[i] <= 32'h0000_0000;
			end
		end
		else if (slotOk && (slotStart || smpValid))
		begin
			posAcc[evtSlot] <= (smpValid && !toNeg) ? satAdd(posBase, smpWide) : posBase;
			negAcc[evtSlot] <= (smpValid && toNeg) ? satAdd(negBase, smpWide) : negBase;
		end
	end

	// end-of-slot: signal/dark forming and decimation of the addressed slot
	logic [31:0] sigIn, darkIn, darkOut, sigOut;
	logic [31:0] integNew [sadec_pkg::CIC_MAX];
	logic [31:0] combNew [sadec_pkg::CIC_MAX];
	logic lastOne, endOk, isImpulse, outDone;

	assign endOk = slotEnd && slotOk;
	assign isImpulse = modeCur == sadec_pkg::SADEC_IMPULSE;
	assign sigIn = (posAcc[evtSlot] > negAcc[evtSlot]) ? posAcc[evtSlot] - negAcc[evtSlot] : 32'h0000_0000;
	assign darkIn = negAcc[evtSlot];
	assign lastOne = decCnt[evtSlot] >= decimCur;
	assign darkOut = darkSum[evtSlot] + darkIn;
	assign outDone = endOk && !isImpulse && lastOne;

	always_comb
	begin
		logic [31:0] v;
		logic [31:0] c;
		v = sigIn;
		c = 32'h0000_0000;
		for (int k = 0; k < sadec_pkg::CIC_MAX; k++)
		begin
			if (3'(k) < orderCur)
			begin
				v = integ[evtSlot][k] + v;
				integNew[k] = v;
			end
			else
				integNew[k] = integ[evtSlot][k];
		end
		c = v;
		for (int k = 0; k < sadec_pkg::CIC_MAX; k++)
		begin
			combNew[k] = c;
			if (3'(k) < orderCur)
				c = c - combDly[evtSlot][k];
			else
				combNew[k] = combDly[evtSlot][k];
		end
		if (orderCur == 3'h0)
			sigOut = sigSum[evtSlot] + sigIn;
		else
			sigOut = c;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < sadec_pkg::NUM_SLOTS; i++)
			begin
				darkSum[i] <= 32'h0000_0000;
				sigSum[i] <= 32'h0000_0000;
				decCnt[i] <= 7'h00;
				for (int k = 0; k < sadec_pkg::CIC_MAX; k++)
				begin
					integ[i][k] <= 32'h0000_0000;
					combDly[i][k] <= 32'h0000_0000;
				end
			end
		end
		else if (endOk && !isImpulse)
		begin
			darkSum[evtSlot] <= lastOne ? 32'h0000_0000 : darkOut;
			sigSum[evtSlot] <= (lastOne || orderCur != 3'h0) ? 32'h0000_0000 : sigOut;
			decCnt[evtSlot] <= lastOne ? 7'h00 : decCnt[evtSlot] + 7'h01;
			for (int k = 0; k < sadec_pkg::CIC_MAX; k++)
			begin
				integ[evtSlot][k] <= integNew[k];
				if (lastOne)
					combDly[evtSlot][k] <= combNew[k];
			end
		end
	end

	// data registers, held while the slot's hold bit is set
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < sadec_pkg::NUM_SLOTS; i++)
			begin
				sigData_reg[i] <= 32'h0000_0000;
				darkData_reg[i] <= 32'h0000_0000;
			end
		end
		else if (outDone && !cfgCur[sadec_pkg::CFG_HOLD_BIT])
		begin
			sigData_reg[evtSlot] <= sigOut;
			darkData_reg[evtSlot] <= darkOut;
		end
	end

	// fifo write: dark word first, then signal word
	logic [1:0] wrNeed;
	logic [31:0] word0, word1, dFmt, sFmt;
	logic wrFits, wrReq, popReq;

	assign dFmt = shiftSat(darkOut, cfgCur[sadec_pkg::CFG_DSHIFT_LSB +: 5], dSize);
	assign sFmt = shiftSat(sigOut, cfgCur[sadec_pkg::CFG_SSHIFT_LSB +: 5], sSize);

	always_comb
	begin
		if (endOk && isImpulse)
		begin
			wrNeed = 2'h1;
			word0 = posAcc[evtSlot];
			word1 = 32'h0000_0000;
		end
		else if (outDone)
		begin
			wrNeed = 2'((dSize != 3'h0) ? 1 : 0) + 2'((sSize != 3'h0) ? 1 : 0);
			word0 = (dSize != 3'h0) ? dFmt : sFmt;
			word1 = sFmt;
		end
		else
		begin
			wrNeed = 2'h0;
			word0 = 32'h0000_0000;
			word1 = 32'h0000_0000;
		end
	end

	assign fifoLevel = wrPtr_reg - rdPtr_reg;
	assign wrFits = (8'(sadec_pkg::FIFO_DEPTH) - fifoLevel) >= {6'h00, wrNeed};
	assign wrReq = (wrNeed != 2'h0) && wrFits;

	always_ff @(posedge sys_clk)
	begin
		if (wrReq)
		begin
			fifoMem[wrPtr_reg[6:0]] <= word0;
			if (wrNeed == 2'h2)
				fifoMem[7'(wrPtr_reg[6:0] + 7'h01)] <= word1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			wrPtr_reg <= 8'h00;
		else if (wrReq)
			wrPtr_reg <= wrPtr_reg + {6'h00, wrNeed};
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rdPtr_reg <= 8'h00;
		else if (popReq && fifoLevel != 8'h00)
			rdPtr_reg <= rdPtr_reg + 8'h01;
	end

	// apb slave, zero wait states, read data captured in setup phase
	logic accessDone;
	logic isWrite;
	logic inSlots;
	logic [3:0] aSlot;
	logic [1:0] aReg;
	logic aSlotOk;
	logic mapped;
	logic [31:0] rdMux;
	logic [11:0] slotOfs;

	assign pready = 1'b1;
	assign accessDone = psel && penable;
	assign isWrite = accessDone && pwrite;
	assign inSlots = paddr >= sadec_pkg::OFS_SLOT_BASE && paddr < sadec_pkg::OFS_SLOT_END;
	assign slotOfs = paddr - sadec_pkg::OFS_SLOT_BASE;
	assign aSlot = slotOfs[7:4];
	assign aReg = paddr[3:2];
	assign aSlotOk = inSlots && aSlot < 4'(sadec_pkg::NUM_SLOTS) && paddr[1:0] == 2'h0;
	assign mapped = aSlotOk || paddr == sadec_pkg::OFS_STATUS ||
		paddr == sadec_pkg::OFS_FIFO_DATA || paddr == sadec_pkg::OFS_FIFO_LEVEL;
	assign popReq = accessDone && !pwrite && paddr == sadec_pkg::OFS_FIFO_DATA;

	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (paddr == sadec_pkg::OFS_STATUS)
			rdMux = {18'h00000, fifoUflow_reg, fifoOflow_reg, dataFlags};
		else if (paddr == sadec_pkg::OFS_FIFO_DATA)
			rdMux = (fifoLevel == 8'h00) ? sadec_pkg::FIFO_EMPTY_WORD : fifoMem[rdPtr_reg[6:0]];
		else if (paddr == sadec_pkg::OFS_FIFO_LEVEL)
			rdMux = {24'h000000, fifoLevel};
		else if (aSlotOk)
		begin
			case (aReg)
				sadec_pkg::SREG_CFG: rdMux = cfgReg[aSlot];
				sadec_pkg::SREG_POL: rdMux = polReg[aSlot];
				sadec_pkg::SREG_SIGNAL: rdMux = sigData_reg[aSlot];
				default: rdMux = darkData_reg[aSlot];
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rdMux;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < sadec_pkg::NUM_SLOTS; i++)
			begin
				cfgReg[i] <= sadec_pkg::CFG_RESET;
				polReg[i] <= sadec_pkg::POL_RESET;
			end
		end
		else if (isWrite && aSlotOk)
		begin
			if (aReg == sadec_pkg::SREG_CFG)
				cfgReg[aSlot] <= pwdata;
			else if (aReg == sadec_pkg::SREG_POL)
				polReg[aSlot] <= pwdata;
		end
	end

	// sticky flags: write one to clear, a new set in the same cycle wins
	logic [11:0] flagSet;
	logic [11:0] flagClr;
	assign flagSet = outDone ? 12'(1 << evtSlot) : 12'h000;
	assign flagClr = (isWrite && paddr == sadec_pkg::OFS_STATUS) ? pwdata[11:0] : 12'h000;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			dataFlags <= 12'h000;
		else
			dataFlags <= (dataFlags & ~flagClr) | flagSet;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			fifoOflow_reg <= 1'b0;
		else if ((wrNeed != 2'h0) && !wrFits)
			fifoOflow_reg <= 1'b1;
		else if (isWrite && paddr == sadec_pkg::OFS_STATUS && pwdata[sadec_pkg::STAT_OFLOW_BIT])
			fifoOflow_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			fifoUflow_reg <= 1'b0;
		else if (popReq && fifoLevel == 8'h00)
			fifoUflow_reg <= 1'b1;
		else if (isWrite && paddr == sadec_pkg::OFS_STATUS && pwdata[sadec_pkg::STAT_UFLOW_BIT])
			fifoUflow_reg <= 1'b0;
	end
endmodule
`default_nettype wire

// File: bench/sadec_top_monitor.sv
// assertion checker for the slot accumulate and decimate block
// assumes it is bound to sadec_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module sadec_top_monitor (
	input wire logic sys_clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [3:0] evtSlot, // event slot
	input wire logic slotEnd, // slot end pulse
	input wire logic [11:0] dataFlags // data flags
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	pready_high_a: assert property (pready)
		else $error("pready low");
	flag_cause_a: assert property ((dataFlags & ~$past(dataFlags)) != 12'h000 |-> $past(slotEnd))
		else $error("flag set without slot end");
	flag_slot_a: assert property ((dataFlags & ~$past(dataFlags)) != 12'h000 |->
		(dataFlags & ~$past(dataFlags)) == (12'h001 << $past(evtSlot)))
		else $error("flag set for wrong slot");
	bad_slot_a: assert property (slotEnd && evtSlot >= 4'hC |=> (dataFlags & ~$past(dataFlags)) == 12'h000)
		else $error("flag from invalid slot");
	flag_clear_a: assert property (($past(dataFlags) & ~dataFlags) != 12'h000 |->
		$past(psel && penable && pwrite && paddr == sadec_pkg::OFS_STATUS))
		else $error("flag cleared without status write");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data changed outside setup");
	slverr_hold_a: assert property (!(psel && !penable) |=> $stable(pslverr))
		else $error("error flag changed outside setup");
	unaligned_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("unaligned access not refused");
endmodule
`default_nettype wire

// File: bench/sadec_adc_src.sv
// behavioural adc sample source driving the slot event inputs
// assumes the bench calls run_slot for one slot frame at a time
`timescale 1ns/10ps
`default_nettype none
module sadec_adc_src (
	input wire logic sys_clk, // clock
	output logic [3:0] evtSlot, // event slot
	output logic slotStart, // start pulse
	output logic slotEnd, // end pulse
	output logic smpValid, // sample pulse
	output logic [13:0] smpData, // sample
	output logic [4:0] smpPulse, // pulse index
	output logic smpDark // dark region
);
	initial
	begin
		evtSlot = 4'h0;
		slotStart = 1'b0;
		slotEnd = 1'b0;
		smpValid = 1'b0;
		smpData = 14'h0000;
		smpPulse = 5'h00;
		smpDark = 1'b0;
	end
	// odd pulses are dark and carry half the value; idle cycles show changing data
	task automatic run_slot(input logic [3:0] s, input logic [13:0] d, input int n, input int gap);
		@(posedge sys_clk);
		evtSlot <= s;
		slotStart <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			slotStart <= 1'b0;
			smpValid <= 1'b1;
			smpPulse <= i[4:0];
			smpDark <= i[0];
			smpData <= i[0] ? d >> 1 : d;
			repeat (gap)
			begin
				@(posedge sys_clk);
				smpValid <= 1'b0;
				smpData <= ~smpData;
			end
		end
		@(posedge sys_clk);
		smpValid <= 1'b0;
		slotEnd <= 1'b1;
		smpData <= ~smpData;
		@(posedge sys_clk);
		slotEnd <= 1'b0;
		smpData <= ~smpData;
	endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench: apb register access plus slot traffic from the sample source
// assumes the checker bound below and a 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rstN = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] evtSlot;
	logic slotStart;
	logic slotEnd;
	logic smpValid;
	logic [13:0] smpData;
	logic [4:0] smpPulse;
	logic smpDark;
	logic [11:0] dataFlags;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	sadec_top u_sadec_top (.sys_clk(clk), .resetn(rstN), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtSlot(evtSlot),
		.slotStart(slotStart), .slotEnd(slotEnd), .smpValid(smpValid), .smpData(smpData), .smpPulse(smpPulse),
		.smpDark(smpDark), .dataFlags(dataFlags));
	sadec_adc_src u_sadec_adc_src (.sys_clk(clk), .evtSlot(evtSlot), .slotStart(slotStart), .slotEnd(slotEnd),
		.smpValid(smpValid), .smpData(smpData), .smpPulse(smpPulse), .smpDark(smpDark));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	function automatic logic [11:0] sreg(input int s, input logic [1:0] r);
		return sadec_pkg::OFS_SLOT_BASE + 12'(s << sadec_pkg::SLOT_STRIDE_SH) + {8'h00, r, 2'b00};
	endfunction
	function automatic logic [31:0] cfg(input int m, input int t, input int r, input int sh, input int sz);
		return 32'(m) | 32'(t) << sadec_pkg::CFG_TYPE_LSB | 32'(r) << sadec_pkg::CFG_DECIM_LSB |
			32'(sh) << sadec_pkg::CFG_SSHIFT_LSB | 32'(sz) << sadec_pkg::CFG_SSIZE_LSB;
	endfunction
	task automatic run(input logic [3:0] s, input logic [13:0] d, input int n, input int g);
		u_sadec_adc_src.run_slot(s, d, n, g);
	endtask
	task automatic fin_test(input string n);
		apb(1'b1, sadec_pkg::OFS_STATUS, 32'h0000_3FFF);
		$display("test %s done", n);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rstN <= 1'b1;
		rchk("cfg0", sreg(0, sadec_pkg::SREG_CFG), sadec_pkg::CFG_RESET);
		rchk("pol0", sreg(0, sadec_pkg::SREG_POL), sadec_pkg::POL_RESET);
		rchk("unmapped", 12'hFFC, 32'h0000_0000);
		apb(1'b0, 12'h002, 32'h0000_0000);
		chk("unaligned", 32'h0000_0001, {31'h0, er});
		run(4'hC, 14'h0064, 1, 0);
		rchk("badslot", sadec_pkg::OFS_STATUS, 32'h0000_0000);
		fin_test("reset");
		apb(1'b1, sreg(0, sadec_pkg::SREG_CFG), cfg(0, 0, 0, 0, 4));
		apb(1'b1, sreg(0, sadec_pkg::SREG_POL), 32'h0000_0002);
		run(4'h0, 14'h0064, 4, 0);
		rchk("signal", sreg(0, sadec_pkg::SREG_SIGNAL), 32'h0000_00C8);
		rchk("dark", sreg(0, sadec_pkg::SREG_DARK), 32'h0000_0032);
		rchk("flags", sadec_pkg::OFS_STATUS, 32'h0000_0001);
		rchk("level", sadec_pkg::OFS_FIFO_LEVEL, 32'h0000_0001);
		rchk("fifo", sadec_pkg::OFS_FIFO_DATA, 32'h0000_00C8);
		rchk("empty", sadec_pkg::OFS_FIFO_DATA, sadec_pkg::FIFO_EMPTY_WORD);
		apb(1'b1, sreg(0, sadec_pkg::SREG_POL), 32'h0000_000F);
		run(4'h0, 14'h0064, 4, 0);
		rchk("clipped", sreg(0, sadec_pkg::SREG_SIGNAL), 32'h0000_0000);
		rchk("fifoclip", sadec_pkg::OFS_FIFO_DATA, 32'h0000_0000);
		fin_test("standard");
		apb(1'b1, sreg(1, sadec_pkg::SREG_CFG), cfg(0, 0, 2, 0, 4));
		apb(1'b1, sreg(2, sadec_pkg::SREG_CFG), cfg(0, 0, 0, 0, 4));
		run(4'h1, 14'h000A, 4, 0);
		run(4'h2, 14'h0008, 4, 0);
		run(4'h1, 14'h000A, 4, 0);
		rchk("partial", sadec_pkg::OFS_STATUS, 32'h0000_0004);
		run(4'h1, 14'h000A, 4, 0);
		rchk("full", sadec_pkg::OFS_STATUS, 32'h0000_0006);
		rchk("sum", sreg(1, sadec_pkg::SREG_SIGNAL), 32'h0000_005A);
		rchk("level2", sadec_pkg::OFS_FIFO_LEVEL, 32'h0000_0002);
		rchk("fifoa", sadec_pkg::OFS_FIFO_DATA, 32'h0000_0018);
		rchk("fifob", sadec_pkg::OFS_FIFO_DATA, 32'h0000_005A);
		fin_test("decimate");
		apb(1'b1, sreg(3, sadec_pkg::SREG_CFG), cfg(0, 0, 3, 2, 4));
		repeat (4) run(4'h3, 14'h0004, 4, 0);
		rchk("average", sadec_pkg::OFS_FIFO_DATA, 32'h0000_000C);
		apb(1'b1, sreg(3, sadec_pkg::SREG_CFG), cfg(0, 0, 0, 0, 1) | (32'h0000_0001 << sadec_pkg::CFG_DSIZE_LSB));
		run(4'h3, 14'h00C8, 4, 0);
		rchk("darkword", sadec_pkg::OFS_FIFO_DATA, 32'h0000_0000);
		rchk("saturate", sadec_pkg::OFS_FIFO_DATA, 32'h0000_00FF);
		fin_test("shift");
		apb(1'b1, sreg(4, sadec_pkg::SREG_CFG), cfg(1, 0, 0, 0, 4));
		run(4'h4, 14'h0064, 4, 2);
		rchk("digint", sreg(4, sadec_pkg::SREG_SIGNAL), 32'h0000_0064);
		rchk("fifodi", sadec_pkg::OFS_FIFO_DATA, 32'h0000_0064);
		fin_test("digint");
		apb(1'b1, sreg(5, sadec_pkg::SREG_CFG), cfg(2, 0, 0, 0, 4));
		run(4'h5, 14'h0064, 2, 0);
		rchk("impulse", sadec_pkg::OFS_FIFO_DATA, 32'h0000_0096);
		rchk("noflag", sadec_pkg::OFS_STATUS, 32'h0000_0000);
		fin_test("impulse");
		apb(1'b1, sreg(6, sadec_pkg::SREG_CFG), cfg(0, 2, 1, 0, 0));
		apb(1'b1, sreg(6, sadec_pkg::SREG_POL), 32'h0000_0002);
		run(4'h6, 14'h0064, 4, 0);
		rchk("cichalf", sadec_pkg::OFS_STATUS, 32'h0000_0000);
		run(4'h6, 14'h0064, 4, 0);
		rchk("darksum", sreg(6, sadec_pkg::SREG_DARK), 32'h0000_0064);
		rchk("cicflag", sadec_pkg::OFS_STATUS, 32'h0000_0040);
		chk("flagpin", 32'h0000_0040, {20'h00000, dataFlags});
		rchk("cicsig", sreg(6, sadec_pkg::SREG_SIGNAL), 32'h0000_0258);
		rchk("nofifo", sadec_pkg::OFS_FIFO_LEVEL, 32'h0000_0000);
		fin_test("cic");
		rstN <= 1'b0;
		repeat (2) @(posedge clk);
		rstN <= 1'b1;
		rchk("rstsig", sreg(6, sadec_pkg::SREG_SIGNAL), 32'h0000_0000);
		rchk("rstcfg", sreg(6, sadec_pkg::SREG_CFG), sadec_pkg::CFG_RESET);
		rchk("rstlevel", sadec_pkg::OFS_FIFO_LEVEL, 32'h0000_0000);
		fin_test("midreset");
		tally_and_finish();
	end
endmodule
bind sadec_top sadec_top_monitor u_sadec_top_monitor (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.evtSlot(evtSlot), .slotEnd(slotEnd), .dataFlags(dataFlags));
`default_nettype wire
